//--- rtl/mosc_pkg.sv
package mosc_pkg;
  // register port geometry
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFS_POLARITY    = 4'h0;  // output_polarity_reg
  localparam logic [3:0]  OFS_PWM_CTRL    = 4'h1;  // pwm_output_control_reg
  localparam logic [3:0]  OFS_SAMPLING    = 4'h2;  // sampling_config_reg
  // reset values
  localparam logic [7:0]  RST_POLARITY    = 8'h3f;
  localparam logic [7:0]  RST_PWM_CTRL    = 8'h00;
  localparam logic [7:0]  RST_SAMPLING    = 8'h02;
  // output_polarity_reg fields
  localparam int          POL_EDGE_BIT    = 7;     // zero_demag_edge_relation
  localparam int          POL_SIDE_BIT    = 6;     // bemf_read_side
  localparam int          POL_CH_LSB      = 0;     // channel_polarity[5:0]
  localparam int          NUM_CH          = 6;
  // pwm_output_control_reg fields
  localparam int          PWC_DEBUG_BIT   = 7;     // debug_event_output
  localparam int          PWC_PHASE_LSB   = 4;     // u,v,w enables at 4,5,6
  localparam int          PWC_OT_LSB      = 0;     // off_time_sel[3:0]
  // sampling_config_reg fields
  localparam int          CFG_DS_LSB      = 4;     // sampling_delay_sel[3:0]
  localparam int          CFG_FLAG_BIT    = 3;     // sampling_out_flag
  localparam int          CFG_MASK_BIT    = 2;     // sampling_out_irq_enable
  localparam int          CFG_PRE_LSB     = 0;     // prescale high/low bits
  // timing: one step is 2.5 us at the reference peripheral clock
  localparam int          STEP_TIME_NS    = 2500;
  localparam int          REF_PERIPH_KHZ  = 4000;
  localparam int          STEP_CYCLES     = STEP_TIME_NS * REF_PERIPH_KHZ / 1000000;
  localparam int          STEP_CNT_W      = 8;
  // prescaler encodings
  localparam logic [1:0]  PRE_DIV1        = 2'h0;
  localparam logic [1:0]  PRE_DIV2        = 2'h1;
endpackage

//--- rtl/mosc_prescaler.sv
`timescale 1ns/1ps
module mosc_prescaler
  import mosc_pkg::*;
(
  input  wire logic       clk_i,      // motor-control clock
  input  wire logic       sys_rst_i,  // sync reset, active high
  input  wire logic [1:0] div_sel_i,  // prescale selection
  output logic            tick_o      // peripheral clock enable pulse
);
  typedef struct packed {
    logic [1:0] cnt;   // free divide counter
    logic       tick;  // registered enable
  } mosc_pre_s;

  mosc_pre_s s;       // current state
  mosc_pre_s next_s;  // next state

  // divide selection: 00 by 1, 01 by 2, 1x by 4
  always_comb begin
    next_s     = s;
    next_s.cnt = s.cnt + 2'h1;
    unique case (div_sel_i)
      PRE_DIV1: next_s.tick = 1'b1;              // [RULE15]
      PRE_DIV2: next_s.tick = s.cnt[0];          // [RULE15]
      default:  next_s.tick = (s.cnt == 2'h3);   // [RULE15]
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;
endmodule

//--- rtl/mosc_step_timer.sv
`timescale 1ns/1ps
module mosc_step_timer
  import mosc_pkg::*;
#(
  parameter int STEPS   = STEP_CYCLES,  // peripheral ticks per step
  parameter int CNT_W   = STEP_CNT_W    // counter width
)(
  input  wire logic       clk_i,      // motor-control clock
  input  wire logic       sys_rst_i,  // sync reset, active high
  input  wire logic       tick_i,     // peripheral clock enable
  input  wire logic       start_i,    // load and run
  input  wire logic       abort_i,    // stop without done
  input  wire logic [4:0] steps_i,    // number of steps, 0 means none
  output logic            busy_o,     // interval running
  output logic            done_o      // one-cycle end pulse
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // ticks left
    logic             busy;  // running
    logic             done;  // end pulse
  } mosc_tmr_s;

  mosc_tmr_s s;       // current state
  mosc_tmr_s next_s;  // next state

  // refuse a counter too narrow for sixteen steps
  if (16 * STEPS >= 2 ** CNT_W || STEPS < 1) begin : g_chk
    $error("step timer counter too narrow");
  end

  // count whole steps of peripheral ticks
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (start_i) begin
      next_s.cnt  = CNT_W'(int'(steps_i) * STEPS);  // [RULE19]
      next_s.busy = (steps_i != 5'h00);
    end else if (abort_i) begin
      next_s.busy = 1'b0;
    end else if (s.busy && tick_i) begin
      if (s.cnt == CNT_W'(1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;
  assign done_o = s.done;
endmodule

//--- rtl/motor_output_sampling_config.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// RULE1: edge relation bit: opposite or same edges
// RULE2: read side bit: high or low channels
// RULE3: software always programs read side bit
// RULE4: motor pin equals inverted polarity xor on-state
// RULE5: channel polarity bits write-once until reset
// RULE6: set polarity before master output enable
// RULE7: debug bit routes events to two pins
// RULE8: per-phase enables gate pwm onto pins
// RULE9: minimum off time (value+1) steps sensorless
// RULE10: nonzero delay samples n steps into on
// RULE11: late on-time sample discarded, flag set
// RULE12: mask enables interrupt, zero sampling only
// RULE13: interrupt only with nonzero sampling delay
// RULE14: software masks interrupt when changing method
// RULE15: prescaler divides by one, two, four
// RULE16: software aims for 4 MHz peripheral clock
// RULE17: reset values 3f, 00, 02
// RULE18: any polarity write locks write-once bits
// RULE19: durations counted in peripheral clock ticks
module motor_output_sampling_config
  import mosc_pkg::*;
(
  input  wire logic              clk_i,                // motor-control clock
  input  wire logic              sys_rst_i,            // sync reset, active high

  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,           // register address
  input  wire logic [7:0]        reg_wdata_i,          // write data
  input  wire logic              reg_wr_i,             // write strobe
  input  wire logic              reg_rd_i,             // read strobe
  output logic      [7:0]        reg_rdata_o,          // read data, next cycle

  // phase and output control from the rest of the unit
  input  wire logic [NUM_CH-1:0] channel_on_state_i,   // on-state per channel
  input  wire logic              master_output_enable_i, // motor pins enabled

  // pwm sources per phase u, v, w
  input  wire logic [2:0]        phase_pwm_i,          // compare pwm, u at bit 0
  input  wire logic              pwm_on_i,             // pwm in on time

  // operating mode
  input  wire logic              sensor_mode_sel_i,    // sensor mode
  input  wire logic              on_time_sampling_sel_i, // on-time sampling
  input  wire logic              zero_sampling_i,      // zero-crossing sampling
  input  wire logic              speed_mode_i,         // speed measurement mode

  // events for debug routing
  input  wire logic              commutation_evt_i,    // commutation event
  input  wire logic              demag_evt_i,          // demagnetisation event
  input  wire logic              zero_evt_i,           // zero-crossing event
  input  wire logic              update_evt_i,         // update event

  // outputs
  output logic      [NUM_CH-1:0] motor_out_pins_o,     // motor output levels
  output logic      [NUM_CH-1:0] motor_out_oe_o,       // motor output enables
  output logic                   phase_u_pwm_pin_o,    // gated u pwm
  output logic                   phase_v_pwm_pin_o,    // gated v pwm
  output logic                   phase_w_pwm_pin_o,    // gated w pwm
  output logic                   debug_demag_pin_o,    // debug event pin
  output logic                   debug_zero_pin_o,     // debug event pin
  output logic                   zero_demag_edge_relation_o, // edge relation
  output logic                   bemf_read_side_o,     // 1 reads low side
  output logic                   periph_tick_o,        // peripheral enable
  output logic                   min_off_active_o,     // minimum off running
  output logic                   sample_strobe_o,      // on-time sample pulse
  output logic                   sampling_out_irq_o    // sampling-out request
);

  // all state of the register bank
  // every output is a flop of this struct or of a submodule,
  // so pins never glitch on decode changes
  // the lock bit is hidden from software
  // and only a reset clears it
  // read data is zero outside its cycle
  typedef struct packed {
    logic [7:0]        pol;     // output_polarity_reg
    logic              locked;  // write-once bits locked
    logic [7:0]        pwc;     // pwm_output_control_reg
    logic [7:0]        cfg;     // sampling_config_reg
    logic [7:0]        rdata;   // read data register
    logic              pwm_q;   // previous pwm_on_i
    logic              sample;  // sample strobe
    logic [NUM_CH-1:0] mout;    // motor pin levels
    logic [NUM_CH-1:0] master_output_enable;     // motor pin enables
    logic [2:0]        ppin;    // gated pwm pins
    logic              dbg_d;   // debug demag pin
    logic              dbg_z;   // debug zero pin
    logic              irq;     // sampling-out request
  } mosc_state_s;

  mosc_state_s s;       // current state
  mosc_state_s next_s;  // next state

  // decoded fields
  // plain wires over the state
  // none of them holds a value
  logic [3:0] delay_sel;      // sampling_delay_sel
  logic [3:0] off_sel;        // off_time_sel
  logic [1:0] pre_sel;        // prescale bits
  logic       pwm_rise;       // pwm on time begins
  logic       pwm_fall;       // pwm on time ends

  logic       off_applies;    // minimum off time in force
  logic       delay_start;    // start on-time delay
  logic       delay_abort;    // on time ended early
  logic       delay_busy;     // delay running
  logic       delay_done;     // delay expired in on time

  logic       off_start;      // start minimum off time
  logic       off_busy;       // minimum off running

  logic       tick;           // peripheral enable

  logic       wr_pol;         // polarity write
  logic       wr_pwc;         // pwm control write
  logic       wr_cfg;         // sampling config write
  logic       late_sample;    // sample fell into off time

  // field views of the registers
  assign delay_sel = s.cfg[CFG_DS_LSB +: 4];
  assign off_sel   = s.pwc[PWC_OT_LSB +: 4];
  assign pre_sel   = s.cfg[CFG_PRE_LSB +: 2];
  // write strobes per register
  // unmapped addresses match none
  assign wr_pol    = reg_wr_i && (reg_addr_i == OFS_POLARITY);
  assign wr_pwc    = reg_wr_i && (reg_addr_i == OFS_PWM_CTRL);
  assign wr_cfg    = reg_wr_i && (reg_addr_i == OFS_SAMPLING);

  // pwm edges, same-clock source so no synchroniser
  // a rise opens the on time
  // a fall closes it
  // each edge lasts one cycle
  assign pwm_rise = pwm_on_i && !s.pwm_q;
  assign pwm_fall = !pwm_on_i && s.pwm_q;

  // on-time delay: only a nonzero delay samples during on time
  // zero keeps sampling in the off time
  assign delay_start = pwm_rise && (delay_sel != 4'h0);      // [RULE10]
  // on time ended before the delay ran out
  assign delay_abort = pwm_fall && delay_busy;
  // a delay ending as the off time begins
  // is late too: discarded and flagged
  assign late_sample = (delay_abort || (delay_done && !pwm_on_i))
                       && zero_sampling_i;                  // [RULE11] [RULE12]

  // minimum off time only sensorless, zero delay, off-time sampling
  // it starts as the on time closes
  // a new on time stops it
  // so does leaving the mode
  assign off_applies = !sensor_mode_sel_i && !on_time_sampling_sel_i
                       && (delay_sel == 4'h0);              // [RULE9]
  assign off_start   = pwm_fall && off_applies;

  // peripheral clock enable
  // all slow logic runs on this pulse
  // a new divide acts within four cycles
  mosc_prescaler u_pre (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .div_sel_i (pre_sel),
    .tick_o    (tick)
  );

  // sampling delay of n steps
  // a fall of the on time aborts it
  // its end pulse gives the sample
  mosc_step_timer #(
    .STEPS (STEP_CYCLES),
    .CNT_W (STEP_CNT_W)
  ) u_delay (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (tick),
    .start_i   (delay_start),
    .abort_i   (delay_abort),
    .steps_i   ({1'b0, delay_sel}),                         // [RULE10]
    .busy_o    (delay_busy),
    .done_o    (delay_done)
  );

  // minimum off time of value+1 steps
  // only busy is used here
  // its end pulse is left open
  mosc_step_timer #(
    .STEPS (STEP_CYCLES),
    .CNT_W (STEP_CNT_W)
  ) u_off (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (tick),
    .start_i   (off_start),
    .abort_i   (!off_applies || pwm_rise),
    .steps_i   ({1'b0, off_sel} + 5'h01),                   // [RULE9]
    .busy_o    (off_busy),
    .done_o    ()
  );

  // next-state logic of the whole bank
  // each field holds unless assigned
  // writes come first, events after,
  // so a hardware event wins
  always_comb begin
    next_s       = s;
    next_s.pwm_q = pwm_on_i;

    // polarity register writes
    // edge and side bits stay writable
    // channel bits take one write only
    // a lock needs no data change
    if (wr_pol) begin
      next_s.pol[POL_EDGE_BIT] = reg_wdata_i[POL_EDGE_BIT];  // [RULE1]
      next_s.pol[POL_SIDE_BIT] = reg_wdata_i[POL_SIDE_BIT];  // [RULE2]
      // first access still loads the channel bits
      if (!s.locked) begin
        next_s.pol[POL_CH_LSB +: NUM_CH] = reg_wdata_i[POL_CH_LSB +: NUM_CH];  // [RULE5]
      end
      // any access locks, even one aimed at other bits
      next_s.locked = 1'b1;                                 // [RULE18]
    end

    // pwm control register is fully writable
    // gating and debug act next cycle
    // off time applies at the next fall
    if (wr_pwc) begin
      next_s.pwc = reg_wdata_i;
    end

    // sampling config: flag clears on written zero
    // a written one leaves the flag
    // divide bits act next cycle
    // delay acts at the next rise
    if (wr_cfg) begin
      next_s.cfg[CFG_DS_LSB +: 4]  = reg_wdata_i[CFG_DS_LSB +: 4];
      next_s.cfg[CFG_MASK_BIT]     = reg_wdata_i[CFG_MASK_BIT];
      next_s.cfg[CFG_PRE_LSB +: 2] = reg_wdata_i[CFG_PRE_LSB +: 2];  // [RULE15]
      if (!reg_wdata_i[CFG_FLAG_BIT]) begin
        next_s.cfg[CFG_FLAG_BIT] = 1'b0;
      end
    end

    // a late sample sets the flag, winning over a clear
    // a clear in the same cycle is lost
    // software sees the flag next read
    if (late_sample) begin
      next_s.cfg[CFG_FLAG_BIT] = 1'b1;                      // [RULE11]
    end

    // sample taken only if the delay expired in on time
    // one clock after the delay ends
    // a single-cycle pulse
    next_s.sample = delay_done && pwm_on_i;                 // [RULE10] [RULE11]

    // request needs flag, mask, nonzero delay, zero sampling
    // the flag shows even while masked
    // a zero delay hides the request
    // but keeps the flag
    next_s.irq = next_s.cfg[CFG_FLAG_BIT] && next_s.cfg[CFG_MASK_BIT]
                 && zero_sampling_i                          // [RULE12]
                 && (next_s.cfg[CFG_DS_LSB +: 4] != 4'h0);   // [RULE13]

    // motor pins per channel
    // enables copy the master enable
    // levels drive whatever the enable
    for (int i = 0; i < NUM_CH; i++) begin
      next_s.mout[i] = ~(s.pol[POL_CH_LSB + i] ^ channel_on_state_i[i]);  // [RULE4]
      next_s.master_output_enable[i]  = master_output_enable_i;
    end

    // phase pwm gating, u at bit 0
    // a cleared enable holds its pin low
    // registered, so one cycle late
    for (int p = 0; p < 3; p++) begin
      next_s.ppin[p] = s.pwc[PWC_PHASE_LSB + p] && phase_pwm_i[p];  // [RULE8]
    end

    // debug event routing
    // pins stay low in normal mode
    // speed mode: commutation and update
    // else events merge per pin
    if (!s.pwc[PWC_DEBUG_BIT]) begin
      next_s.dbg_d = 1'b0;
      next_s.dbg_z = 1'b0;
    end else if (speed_mode_i) begin
      next_s.dbg_d = commutation_evt_i;                     // [RULE7]
      next_s.dbg_z = update_evt_i;                          // [RULE7]
    end else begin
      next_s.dbg_d = commutation_evt_i || demag_evt_i;      // [RULE7]
      next_s.dbg_z = commutation_evt_i || zero_evt_i;       // [RULE7]
    end

    // read data stands one cycle after the strobe
    // then returns to zero
    // the master never waits
    next_s.rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_POLARITY: next_s.rdata = s.pol;
        OFS_PWM_CTRL: next_s.rdata = s.pwc;
        OFS_SAMPLING: next_s.rdata = s.cfg;
        default:      next_s.rdata = 8'h00;
      endcase
    end
  end

  // state register with documented reset values
  // reset releases the lock
  // motor pins idle high
  // all else clears to zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s        <= '0;
      s.pol    <= RST_POLARITY;                             // [RULE17]
      s.pwc    <= RST_PWM_CTRL;                             // [RULE17]
      s.cfg    <= RST_SAMPLING;                             // [RULE17]
      s.locked <= 1'b0;
      s.mout   <= '1;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  // all from flops or the enable
  // no decode logic reaches a pin
  assign reg_rdata_o                = s.rdata;
  assign motor_out_pins_o           = s.mout;
  assign motor_out_oe_o             = s.master_output_enable;
  assign phase_u_pwm_pin_o          = s.ppin[0];
  assign phase_v_pwm_pin_o          = s.ppin[1];
  assign phase_w_pwm_pin_o          = s.ppin[2];
  assign debug_demag_pin_o          = s.dbg_d;
  assign debug_zero_pin_o           = s.dbg_z;
  assign zero_demag_edge_relation_o = s.pol[POL_EDGE_BIT];  // [RULE1]
  assign bemf_read_side_o           = s.pol[POL_SIDE_BIT];  // [RULE2]
  assign periph_tick_o              = tick;
  assign min_off_active_o           = off_busy;             // [RULE9]
  assign sample_strobe_o            = s.sample;
  assign sampling_out_irq_o         = s.irq;                // [RULE12]

endmodule

//--- sim/mosc_checker_properties.sv
`timescale 1ns/1ps
module mosc_checker (
  input wire logic       clk_i,                  // clock
  input wire logic       sys_rst_i,              // reset
  input wire logic [2:0] phase_pwm_i,            // pwm sources
  input wire logic       pwm_on_i,               // on time
  input wire logic       sensor_mode_sel_i,      // sensor mode
  input wire logic       on_time_sampling_sel_i, // on sampling
  input wire logic       zero_sampling_i,        // zero sampling
  input wire logic       commutation_evt_i,      // c event
  input wire logic       demag_evt_i,            // d event
  input wire logic       zero_evt_i,             // z event
  input wire logic       update_evt_i,           // u event
  input wire logic       phase_u_pwm_pin_o,      // u pin
  input wire logic       phase_v_pwm_pin_o,      // v pin
  input wire logic       phase_w_pwm_pin_o,      // w pin
  input wire logic       debug_demag_pin_o,      // debug pin
  input wire logic       debug_zero_pin_o,       // debug pin
  input wire logic       periph_tick_o,          // periph tick
  input wire logic       min_off_active_o,       // min off
  input wire logic       sample_strobe_o,        // sample pulse
  input wire logic       sampling_out_irq_o      // irq
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // a gated pin only rises when its source was high
  property p_pwm_gate;
    ({phase_w_pwm_pin_o, phase_v_pwm_pin_o, phase_u_pwm_pin_o} & ~$past(phase_pwm_i)) == 3'h0;
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("pwm pin without source");
  // debug pins only carry real events
  property p_dbg_demag;
    debug_demag_pin_o |-> ($past(commutation_evt_i) || $past(demag_evt_i));
  endproperty
  a_dbg_demag: assert property (p_dbg_demag) else $error("demag pin without event");
  property p_dbg_zero;
    debug_zero_pin_o |-> ($past(commutation_evt_i) || $past(zero_evt_i) || $past(update_evt_i));
  endproperty
  a_dbg_zero: assert property (p_dbg_zero) else $error("zero pin without event");
  // request only for zero-crossing sampling
  property p_irq_zero;
    sampling_out_irq_o |-> $past(zero_sampling_i);
  endproperty
  a_irq_zero: assert property (p_irq_zero) else $error("irq outside zero sampling");
  // slowest division is four
  property p_tick_gap;
    periph_tick_o |-> ##[1:4] periph_tick_o;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick gap above four");
  // sample only taken inside on time
  property p_strobe_on;
    sample_strobe_o |-> $past(pwm_on_i);
  endproperty
  a_strobe_on: assert property (p_strobe_on) else $error("sample outside on time");
  property p_strobe_pulse;
    sample_strobe_o |=> !sample_strobe_o;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("sample pulse too long");
  // minimum off only starts in sensorless off-time sampling
  property p_moff_start;
    $rose(min_off_active_o) |-> (!$past(pwm_on_i) && !$past(sensor_mode_sel_i)
                                 && !$past(on_time_sampling_sel_i));
  endproperty
  a_moff_start: assert property (p_moff_start) else $error("min off in wrong mode");
endmodule

//--- sim/mosc_inverter_model.sv
`timescale 1ns/1ps
// bridge switches conduct only while the pin is enabled and high
module mosc_inverter_model (
  input  wire logic [5:0] pins_i,      // pin levels
  input  wire logic [5:0] oe_i,        // pin enables
  output logic      [5:0] bridge_on_o  // conducting switches
);
  assign bridge_on_o = oe_i & pins_i;
endmodule

//--- sim/motor_output_sampling_config_bench.sv
`timescale 1ns/1ps
module motor_output_sampling_config_bench;
  import mosc_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, master_output_enable_i = 0, pwm_on_i = 0;
  logic sensor_mode_sel_i = 0, on_time_sampling_sel_i = 0, zero_sampling_i = 0, speed_mode_i = 0;
  logic commutation_evt_i = 0, demag_evt_i = 0, zero_evt_i = 0, update_evt_i = 0;
  logic [3:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o;
  logic [5:0] channel_on_state_i = 0, motor_out_pins_o, motor_out_oe_o, bridge_on;
  logic [2:0] phase_pwm_i = 0;
  logic phase_u_pwm_pin_o, phase_v_pwm_pin_o, phase_w_pwm_pin_o, debug_demag_pin_o, debug_zero_pin_o;
  logic zero_demag_edge_relation_o, bemf_read_side_o, periph_tick_o, min_off_active_o;
  logic sample_strobe_o, sampling_out_irq_o;
  logic [6:0] dbg_tab [6];  // events c,d,z,u, speed, demag pin, zero pin
  int   error_cnt = 0;
  int   compares = 0;
  int   n;
  always #2 clk_i = ~clk_i;
  motor_output_sampling_config DUT (.*);
  mosc_inverter_model u_bridge (.pins_i(motor_out_pins_o), .oe_i(motor_out_oe_o), .bridge_on_o(bridge_on));
  task give_verdict;
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // one-cycle write strobe
  task wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clk_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= dt;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  // read data looked at in the cycle after the strobe
  task rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // ticks seen over forty cycles
  task ticks(input logic [7:0] e);
    cyc(4);
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      #1 n += (periph_tick_o === 1'b1);
    end
    chk(n[7:0], e);
  endtask
  // short on pulse ending before the delay runs out
  task late_pulse;
    cyc(1);
    pwm_on_i <= 1'b1;
    cyc(3);
    pwm_on_i <= 1'b0;
    cyc(20);
  endtask
  // watchdog: the tests need under two thousand cycles
  initial begin
    #60000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    dbg_tab = '{7'b0100_0_10, 7'b0010_0_01, 7'b1000_0_11, 7'b0001_1_01, 7'b0100_1_00, 7'b0000_0_00};
    cyc(12);
    sys_rst_i <= 1'b0;
    rd(OFS_POLARITY, RST_POLARITY);
    rd(OFS_PWM_CTRL, RST_PWM_CTRL);
    rd(OFS_SAMPLING, RST_SAMPLING);
    rd(4'hf, 8'h00);
    ticks(8'h0a);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SAMPLING, i[7:0]);
      ticks(i == 0 ? 8'h28 : (i == 1 ? 8'h14 : 8'h0a));
    end
    // reset polarity is all high, so pins follow the on-state
    channel_on_state_i <= 6'h0c;
    cyc(3);
    chk({2'b0, motor_out_pins_o}, 8'h0c);
    wr(OFS_POLARITY, 8'h15);
    rd(OFS_POLARITY, 8'h15);
    wr(OFS_POLARITY, 8'hea);
    rd(OFS_POLARITY, 8'hd5);
    chk({6'b0, zero_demag_edge_relation_o, bemf_read_side_o}, 8'h03);
    wr(OFS_POLARITY, 8'h00);
    cyc(1);
    chk({6'b0, zero_demag_edge_relation_o, bemf_read_side_o}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      channel_on_state_i <= (i == 0) ? 6'h00 : (i == 1 ? 6'h0f : 6'h3f);
      cyc(3);
      chk({2'b0, motor_out_pins_o}, {2'b0, ~(6'h15 ^ channel_on_state_i)});
    end
    // polarity is settled, now the bridge may be enabled
    master_output_enable_i <= 1'b1;
    cyc(3);
    chk({2'b0, bridge_on}, 8'h15);
    phase_pwm_i <= 3'h7;
    wr(OFS_PWM_CTRL, 8'h50);
    cyc(2);
    chk({5'b0, phase_w_pwm_pin_o, phase_v_pwm_pin_o, phase_u_pwm_pin_o}, 8'h05);
    wr(OFS_PWM_CTRL, 8'h20);
    cyc(2);
    chk({5'b0, phase_w_pwm_pin_o, phase_v_pwm_pin_o, phase_u_pwm_pin_o}, 8'h02);
    wr(OFS_PWM_CTRL, 8'h80);
    for (int i = 0; i < 6; i++) begin
      if (i == 5) wr(OFS_PWM_CTRL, 8'h00);
      cyc(1);
      {commutation_evt_i, demag_evt_i, zero_evt_i, update_evt_i} <= (i == 5) ? 4'b0100 : dbg_tab[i][6:3];
      speed_mode_i <= dbg_tab[i][2];
      cyc(3);
      chk({6'b0, debug_demag_pin_o, debug_zero_pin_o}, {6'b0, dbg_tab[i][1:0]});
    end
    // delay of one step, no prescaling
    zero_sampling_i <= 1'b1;
    wr(OFS_SAMPLING, 8'h14);
    cyc(1);
    pwm_on_i <= 1'b1;
    n = 0;
    while (sample_strobe_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk({7'b0, n inside {[STEP_CYCLES:STEP_CYCLES + 4]}}, 8'h01);
    cyc(1);
    pwm_on_i <= 1'b0;
    for (int m = 1; m >= 0; m--) begin
      wr(OFS_SAMPLING, 8'h10 | (m[7:0] << 2));
      late_pulse();
      rd(OFS_SAMPLING, 8'h18 | (m[7:0] << 2));
      chk({7'b0, sampling_out_irq_o}, m[7:0]);
      wr(OFS_SAMPLING, 8'h0c);
      rd(OFS_SAMPLING, 8'h0c);
      chk({7'b0, sampling_out_irq_o}, 8'h00);
      wr(OFS_SAMPLING, 8'h10);
      rd(OFS_SAMPLING, 8'h10);
    end
    wr(OFS_SAMPLING, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PWM_CTRL, (i == 0) ? 8'h00 : 8'h0f);
      sensor_mode_sel_i      <= (i == 2);
      on_time_sampling_sel_i <= (i == 3);
      cyc(2);
      pwm_on_i <= 1'b1;
      cyc(2);
      pwm_on_i <= 1'b0;
      n = 0;
      repeat (250) begin
        @(posedge clk_i);
        #1 n += (min_off_active_o === 1'b1);
      end
      chk(n[7:0], 8'((i == 0) ? STEP_CYCLES : (i == 1 ? 16 * STEP_CYCLES : 0)));
    end
    give_verdict();
  end
endmodule
bind motor_output_sampling_config mosc_checker u_chk (.*);
